// ==== rtl/serial_evt_pkg.sv ====
// Purpose: shared constants for the serial task/event register block
// Assumes: 32-bit register port, byte addresses as printed
// Notes: channel index is 16 bits wide, enable in the top bit
package serial_evt_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CHAN_W = 16;
    localparam int NUM_TASKS = 5;
    localparam int NUM_EVENTS = 11;
    // Channel fabric width and the index bits that select one channel
    localparam int NUM_CH = 16;
    localparam int CH_SEL_W = 4;
    // Task trigger offsets
    localparam logic [11:0] OFF_RX_START_TRIG = 12'h000;
    localparam logic [11:0] OFF_RX_STOP_TRIG = 12'h004;
    localparam logic [11:0] OFF_TX_START_TRIG = 12'h008;
    localparam logic [11:0] OFF_TX_STOP_TRIG = 12'h00C;
    localparam logic [11:0] OFF_RX_FLUSH_TRIG = 12'h02C;
    // Subscription offsets
    localparam logic [11:0] OFF_RX_START_SUB = 12'h080;
    localparam logic [11:0] OFF_RX_STOP_SUB = 12'h084;
    localparam logic [11:0] OFF_TX_START_SUB = 12'h088;
    localparam logic [11:0] OFF_TX_STOP_SUB = 12'h08C;
    localparam logic [11:0] OFF_RX_FLUSH_SUB = 12'h0AC;
    // Event flag offsets
    localparam logic [11:0] OFF_CTS_ACT = 12'h100;
    localparam logic [11:0] OFF_CTS_INACT = 12'h104;
    localparam logic [11:0] OFF_BYTE_RX = 12'h108;
    localparam logic [11:0] OFF_RX_FULL = 12'h110;
    localparam logic [11:0] OFF_BYTE_TX = 12'h11C;
    localparam logic [11:0] OFF_TX_DONE = 12'h120;
    localparam logic [11:0] OFF_ERROR = 12'h124;
    localparam logic [11:0] OFF_RX_TIMEOUT = 12'h144;
    localparam logic [11:0] OFF_RX_STARTED = 12'h14C;
    localparam logic [11:0] OFF_TX_STARTED = 12'h150;
    localparam logic [11:0] OFF_TX_STOPPED = 12'h158;
    // Interrupt mask offset
    localparam logic [11:0] OFF_IRQ_MASK = 12'h300;
    localparam int SUB_EN_BIT = 31;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    // Task indices
    localparam int T_RX_START = 0;
    localparam int T_RX_STOP = 1;
    localparam int T_TX_START = 2;
    localparam int T_TX_STOP = 3;
    localparam int T_RX_FLUSH = 4;
    // Event indices, same layout in the mask register
    localparam int E_CTS_ACT = 0;
    localparam int E_CTS_INACT = 1;
    localparam int E_BYTE_RX = 2;
    localparam int E_RX_FULL = 3;
    localparam int E_BYTE_TX = 4;
    localparam int E_TX_DONE = 5;
    localparam int E_ERROR = 6;
    localparam int E_RX_TIMEOUT = 7;
    localparam int E_RX_STARTED = 8;
    localparam int E_TX_STARTED = 9;
    localparam int E_TX_STOPPED = 10;
endpackage

// ==== rtl/task_sub_if.sv ====
// Purpose: carries one subscription configuration and its channel fabric hit
// Assumes: single clock domain
// Notes: the register block drives the config, the matcher drives the hit
`timescale 1ns/10ps
interface task_sub_if;
    import serial_evt_pkg::*;
    logic [CHAN_W-1:0] chan;
    logic en;
    logic hit;
    modport regs (output chan, output en, input hit);
    modport match (input chan, input en, output hit);
endinterface

// ==== rtl/task_sub_match.sv ====
// Purpose: fires a task when the subscribed channel signals
// Assumes: i_chan_pulse is a one-hot-per-channel pulse vector of the fabric
// Notes: hit is registered, one cycle after the channel pulse
`timescale 1ns/10ps
module task_sub_match
    import serial_evt_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [serial_evt_pkg::NUM_CH-1:0] i_chan_pulse,
    task_sub_if.match sub
);
    typedef struct packed {
        logic hit;
    } match_state_t;
    match_state_t state_r;
    match_state_t state_nxt;

    // Subscription fires only with enable set and an index in range
    always_comb begin
        state_nxt = state_r;
        state_nxt.hit = sub.en && (sub.chan < CHAN_W'(NUM_CH)) && i_chan_pulse[sub.chan[CH_SEL_W-1:0]]; // [RQ2]
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sub.hit = state_r.hit;
endmodule

// ==== rtl/serial_evt_regs.sv ====
// Purpose: task triggers, subscriptions, event flags and interrupt of the serial unit
// Assumes: register port with one-cycle strobes, read data in the next cycle
// Notes: datapath pulses arrive as single-cycle inputs; tasks leave as pulses
//
// Notes on behaviour
// [RQ1] Writing 1 to the flush trigger pulses the flush task toward the receive FIFO.
// [RQ2] Each task has a subscription: channel index plus enable, both reset to zero.
// [RQ3] Clear-to-send going low sets the clear-to-send active flag.
// [RQ4] Clear-to-send going high sets the clear-to-send inactive flag.
// [RQ5] A received byte sets the byte received flag, maybe before it reaches RAM.
// [RQ6] A completely filled receive buffer sets the receive buffer full flag.
// [RQ7] Transmission of the last buffer byte sets the transmit done flag.
// [RQ8] The receiver actually starting sets the receiver started flag.
// [RQ9] The transmitter actually starting sets the transmitter started flag.
// [RQ10] The receiver fully stopping after a stop task sets the receiver timeout flag.
// [RQ11] A framing error or a break condition sets the error flag.
// [RQ12] Software waits for stopped or timeout events before disabling the unit.
// [RQ13] Writing 1 to start or stop triggers acts; writing 0 does nothing; write-only.
// [RQ14] Flags hold 1 until written 0; each sent byte sets the byte sent flag.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
module serial_evt_regs
    import serial_evt_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [serial_evt_pkg::ADDR_W-1:0] i_addr,
    input wire logic [serial_evt_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [serial_evt_pkg::DATA_W-1:0] o_rdata,
    input wire logic [serial_evt_pkg::NUM_CH-1:0] i_chan_pulse,
    input wire logic i_cts_n,
    input wire logic i_rx_byte,
    input wire logic i_rx_buf_full,
    input wire logic i_tx_byte,
    input wire logic i_tx_last,
    input wire logic i_rx_started,
    input wire logic i_tx_started,
    input wire logic i_rx_stopped,
    input wire logic i_tx_stopped,
    input wire logic i_frame_err,
    input wire logic i_break,
    output logic [serial_evt_pkg::NUM_TASKS-1:0] o_task,
    output logic o_irq
);
    import serial_evt_pkg::*;

    typedef struct packed {
        logic [NUM_TASKS-1:0][CHAN_W-1:0] sub_chan;
        logic [NUM_TASKS-1:0] sub_en;
        logic [NUM_EVENTS-1:0] flags;
        logic [NUM_EVENTS-1:0] mask;
        logic [NUM_TASKS-1:0] task_out;
        logic cts_prev;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } regs_state_t;

    regs_state_t state_r;
    regs_state_t state_nxt;
    logic [NUM_TASKS-1:0] sub_hit;
    logic [NUM_TASKS-1:0] sw_trig;
    logic [NUM_EVENTS-1:0] hw_set;
    logic [NUM_EVENTS-1:0] sw_clr;
    logic [NUM_TASKS-1:0] sub_wr;
    logic [NUM_EVENTS-1:0] flag_sel;

    // One matcher per task subscription
    for (genvar t = 0; t < NUM_TASKS; t++) begin : g_sub
        task_sub_if sub_bus ();
        assign sub_bus.chan = state_r.sub_chan[t];
        assign sub_bus.en = state_r.sub_en[t];
        assign sub_hit[t] = sub_bus.hit;
        task_sub_match u_match (
            .i_ref_clk(i_ref_clk),
            .i_rstn(i_rstn),
            .i_chan_pulse(i_chan_pulse),
            .sub(sub_bus)
        );
    end

    // Address decode for trigger, subscription and flag writes
    always_comb begin
        sw_trig = '0;
        sub_wr = '0;
        flag_sel = '0;
        case (i_addr)
            OFF_RX_START_TRIG: sw_trig[T_RX_START] = 1'b1;
            OFF_RX_STOP_TRIG: sw_trig[T_RX_STOP] = 1'b1;
            OFF_TX_START_TRIG: sw_trig[T_TX_START] = 1'b1;
            OFF_TX_STOP_TRIG: sw_trig[T_TX_STOP] = 1'b1;
            OFF_RX_FLUSH_TRIG: sw_trig[T_RX_FLUSH] = 1'b1;
            OFF_RX_START_SUB: sub_wr[T_RX_START] = 1'b1;
            OFF_RX_STOP_SUB: sub_wr[T_RX_STOP] = 1'b1;
            OFF_TX_START_SUB: sub_wr[T_TX_START] = 1'b1;
            OFF_TX_STOP_SUB: sub_wr[T_TX_STOP] = 1'b1;
            OFF_RX_FLUSH_SUB: sub_wr[T_RX_FLUSH] = 1'b1;
            OFF_CTS_ACT: flag_sel[E_CTS_ACT] = 1'b1;
            OFF_CTS_INACT: flag_sel[E_CTS_INACT] = 1'b1;
            OFF_BYTE_RX: flag_sel[E_BYTE_RX] = 1'b1;
            OFF_RX_FULL: flag_sel[E_RX_FULL] = 1'b1;
            OFF_BYTE_TX: flag_sel[E_BYTE_TX] = 1'b1;
            OFF_TX_DONE: flag_sel[E_TX_DONE] = 1'b1;
            OFF_ERROR: flag_sel[E_ERROR] = 1'b1;
            OFF_RX_TIMEOUT: flag_sel[E_RX_TIMEOUT] = 1'b1;
            OFF_RX_STARTED: flag_sel[E_RX_STARTED] = 1'b1;
            OFF_TX_STARTED: flag_sel[E_TX_STARTED] = 1'b1;
            OFF_TX_STOPPED: flag_sel[E_TX_STOPPED] = 1'b1;
            default: begin
                sw_trig = '0;
            end
        endcase
        // Only a write of 1 triggers; 0 is ignored
        sw_trig = (i_wr && i_wdata[0]) ? sw_trig : '0; // [RQ13] [RQ1]
        sub_wr = i_wr ? sub_wr : '0;
        // Writing 0 to a flag clears it
        sw_clr = (i_wr && !i_wdata[0]) ? flag_sel : '0; // [RQ14]
    end

    // Hardware event sources
    always_comb begin
        hw_set = '0;
        hw_set[E_CTS_ACT] = state_r.cts_prev && !i_cts_n; // [RQ3]
        hw_set[E_CTS_INACT] = !state_r.cts_prev && i_cts_n; // [RQ4]
        hw_set[E_BYTE_RX] = i_rx_byte; // [RQ5]
        hw_set[E_RX_FULL] = i_rx_buf_full; // [RQ6]
        hw_set[E_BYTE_TX] = i_tx_byte; // [RQ14]
        hw_set[E_TX_DONE] = i_tx_last; // [RQ7]
        hw_set[E_ERROR] = i_frame_err || i_break; // [RQ11]
        hw_set[E_RX_TIMEOUT] = i_rx_stopped; // [RQ10]
        hw_set[E_RX_STARTED] = i_rx_started; // [RQ8]
        hw_set[E_TX_STARTED] = i_tx_started; // [RQ9]
        hw_set[E_TX_STOPPED] = i_tx_stopped;
    end

    // Next-state logic for all registers
    always_comb begin
        state_nxt = state_r;
        state_nxt.cts_prev = i_cts_n;
        // Set wins over a clear in the same cycle
        state_nxt.flags = (state_r.flags & ~sw_clr) | hw_set; // [RQ14]
        // Task pulses from software or from a subscribed channel
        state_nxt.task_out = sw_trig | sub_hit; // [RQ2] [RQ13]
        for (int t = 0; t < NUM_TASKS; t++) begin
            if (sub_wr[t]) begin
                state_nxt.sub_chan[t] = i_wdata[CHAN_W-1:0]; // [RQ2]
                state_nxt.sub_en[t] = i_wdata[SUB_EN_BIT];
            end
        end
        if (i_wr && i_addr == OFF_IRQ_MASK) begin
            state_nxt.mask = i_wdata[NUM_EVENTS-1:0];
        end
        state_nxt.irq = |(state_nxt.flags & state_nxt.mask);
        state_nxt.rdata = RESET_WORD;
        if (i_rd) begin
            for (int t = 0; t < NUM_TASKS; t++) begin
                if (sub_wr[t] == 1'b0 && i_addr == (t == T_RX_FLUSH ? OFF_RX_FLUSH_SUB :
                        OFF_RX_START_SUB + ADDR_W'(4 * t))) begin
                    state_nxt.rdata = {state_r.sub_en[t], 15'h0000, state_r.sub_chan[t]};
                end
            end
            for (int e = 0; e < NUM_EVENTS; e++) begin
                if (flag_sel[e]) begin
                    state_nxt.rdata = {31'h00000000, state_r.flags[e]};
                end
            end
            if (i_addr == OFF_IRQ_MASK) begin
                state_nxt.rdata = {21'h000000, state_r.mask};
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state_r <= '0;
            state_r.cts_prev <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_rdata = state_r.rdata;
    assign o_task = state_r.task_out;
    assign o_irq = state_r.irq;

    // Checks
    property p_cts_fall;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            $fell(i_cts_n) |=> state_r.flags[E_CTS_ACT];
    endproperty
    a_cts_fall: assert property (p_cts_fall) else $error("cts active flag not set"); // [RQ3]
    property p_cts_rise;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            $rose(i_cts_n) |=> state_r.flags[E_CTS_INACT];
    endproperty
    a_cts_rise: assert property (p_cts_rise) else $error("cts inactive flag not set"); // [RQ4]
    property p_flush;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (i_wr && i_addr == OFF_RX_FLUSH_TRIG && i_wdata[0]) |=> o_task[T_RX_FLUSH];
    endproperty
    a_flush: assert property (p_flush) else $error("flush task missing"); // [RQ1]
    property p_zero_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (i_wr && i_addr == OFF_TX_START_TRIG && !i_wdata[0] && !sub_hit[T_TX_START])
            |=> !o_task[T_TX_START];
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write triggered"); // [RQ13]
    property p_sub_off;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            !state_r.sub_en[T_RX_STOP] ##1 !state_r.sub_en[T_RX_STOP] |-> !sub_hit[T_RX_STOP];
    endproperty
    a_sub_off: assert property (p_sub_off) else $error("disabled subscription fired"); // [RQ2]
    property p_rx_byte;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            i_rx_byte |=> state_r.flags[E_BYTE_RX];
    endproperty
    a_rx_byte: assert property (p_rx_byte) else $error("byte received flag not set"); // [RQ5]
    property p_error;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (i_frame_err || i_break) |=> state_r.flags[E_ERROR];
    endproperty
    a_error: assert property (p_error) else $error("error flag not set"); // [RQ11]
    property p_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (state_r.flags[E_TX_DONE] && !sw_clr[E_TX_DONE]) |=> state_r.flags[E_TX_DONE];
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost without clear"); // [RQ14]
    property p_misc;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (!i_wr && hw_set == '0) |=> $stable(state_r.flags);
    endproperty
    a_misc: assert property (p_misc) else $error("flag changed with no event or write"); // [RQ14]
    property p_irq;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            ##1 (o_irq == |(state_r.flags & state_r.mask));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    // Receive buffer filled
    property p_rx_full;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            i_rx_buf_full |=> state_r.flags[E_RX_FULL];
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("buffer full flag not set"); // [RQ6]

    // Last transmit byte gone
    property p_tx_done;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            i_tx_last |=> state_r.flags[E_TX_DONE];
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("transmit done flag not set"); // [RQ7]

    // Receiver running
    property p_rx_started;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            i_rx_started |=> state_r.flags[E_RX_STARTED];
    endproperty
    a_rx_started: assert property (p_rx_started) else $error("receiver started flag not set"); // [RQ8]

    // Transmitter running
    property p_tx_started;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            i_tx_started |=> state_r.flags[E_TX_STARTED];
    endproperty
    a_tx_started: assert property (p_tx_started) else $error("transmitter started flag not set"); // [RQ9]

    // Receiver fully stopped
    property p_rx_timeout;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            i_rx_stopped |=> state_r.flags[E_RX_TIMEOUT];
    endproperty
    a_rx_timeout: assert property (p_rx_timeout) else $error("receiver timeout flag not set"); // [RQ10]

    // Byte left the transmit line
    property p_byte_tx;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            i_tx_byte |=> state_r.flags[E_BYTE_TX];
    endproperty
    a_byte_tx: assert property (p_byte_tx) else $error("byte sent flag not set"); // [RQ14]

    // Transmitter stopped
    property p_tx_stopped;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            i_tx_stopped |=> state_r.flags[E_TX_STOPPED];
    endproperty
    a_tx_stopped: assert property (p_tx_stopped) else $error("transmitter stopped flag not set");

    // Writing 0 clears a flag when no event sets it in the same cycle
    property p_sw_clear;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (i_wr && i_addr == OFF_BYTE_TX && !i_wdata[0] && !i_tx_byte) |=> !state_r.flags[E_BYTE_TX];
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("flag not cleared by zero write"); // [RQ14]

    // Trigger registers are write-only and read back as zero
    property p_trig_read;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (i_rd && (i_addr == OFF_RX_START_TRIG || i_addr == OFF_TX_STOP_TRIG
            || i_addr == OFF_RX_FLUSH_TRIG)) |=> (o_rdata == RESET_WORD);
    endproperty
    a_trig_read: assert property (p_trig_read) else $error("trigger register read not zero"); // [RQ13]

    // Read data stand for one cycle only
    property p_rdata_idle;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            !i_rd |=> (o_rdata == RESET_WORD);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

    // A task pulse lasts one cycle unless triggered again
    property p_task_pulse;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (o_task[T_RX_FLUSH] && !i_wr && !sub_hit[T_RX_FLUSH]) |=> !o_task[T_RX_FLUSH];
    endproperty
    a_task_pulse: assert property (p_task_pulse) else $error("flush task longer than one cycle"); // [RQ1]

    // Subscribed channel fires its task two cycles later
    property p_sub_fire;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (state_r.sub_en[T_TX_STOP] && state_r.sub_chan[T_TX_STOP] < CHAN_W'(NUM_CH)
            && i_chan_pulse[state_r.sub_chan[T_TX_STOP][CH_SEL_W-1:0]]) |=> ##1 o_task[T_TX_STOP];
    endproperty
    a_sub_fire: assert property (p_sub_fire) else $error("subscribed task did not fire"); // [RQ2]

    // A cleared mask keeps the interrupt low
    property p_mask_off;
        @(posedge i_ref_clk) disable iff (!i_rstn)
            (state_r.mask == '0 && !i_wr) |=> !o_irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq with empty mask");
    c_flush: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_task[T_RX_FLUSH]);
    c_irq: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) $rose(o_irq));
    c_sub: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) |sub_hit);
    c_clear: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) $fell(state_r.flags[E_ERROR]));
    c_cts: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) $rose(state_r.flags[E_CTS_ACT]));
endmodule

// ==== verif/far_serial_model.sv ====
// Purpose: far side of the serial unit: clear-to-send pin and datapath event pulses
// Assumes: the bench asks for one event at a time
// Notes: answers at once or after a delay, to show the flags do not care when
`timescale 1ns/10ps
module far_serial_model (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_go,
    input wire logic [3:0] i_sel,
    input wire logic [3:0] i_delay,
    input wire logic i_cts_req,
    output logic [9:0] o_evt,
    output logic o_cts_n
);
    logic [3:0] wait_r;
    logic [3:0] sel_r;
    logic busy_r;
    // Pin idles high; each requested event leaves as a one-cycle pulse after the delay
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            busy_r <= 1'b0;
            o_cts_n <= 1'b1;
            o_evt <= '0;
        end else begin
            o_cts_n <= ~i_cts_req;
            o_evt <= (!i_go && busy_r && wait_r == 4'h0) ? 10'h001 << sel_r : 10'h000;
            if (i_go) begin
                busy_r <= 1'b1;
                wait_r <= i_delay;
                sel_r <= i_sel;
            end else if (busy_r && wait_r == 4'h0) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                wait_r <= wait_r - 4'h1;
            end
        end
    end
endmodule

// ==== verif/test_serial_evt_regs.sv ====
// Purpose: self-checking bench of the serial task/event register block
// Assumes: one-cycle register strobes, read data in the cycle after the read
// Notes: event rows run in a table loop; triggers, subscriptions and pins follow
`timescale 1ns/10ps
module test_serial_evt_regs;
    import serial_evt_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic [15:0] i_chan_pulse = '0;
    logic [NUM_TASKS-1:0] o_task;
    logic o_irq;
    logic [9:0] evt;
    logic cts_n;
    logic go = 1'b0;
    logic [3:0] sel = '0;
    logic [3:0] dly = '0;
    logic cts_req = 1'b0;
    int num_errors = 0;
    int n_compared = 0;
    logic [DATA_W-1:0] rv;
    // Event select, flag offset, mask bit
    typedef struct {logic [3:0] s; logic [11:0] off; int bit_i;} row_t;
    row_t rows[10] = '{'{4'h0, OFF_BYTE_RX, E_BYTE_RX}, '{4'h1, OFF_RX_FULL, E_RX_FULL},
        '{4'h2, OFF_BYTE_TX, E_BYTE_TX}, '{4'h3, OFF_TX_DONE, E_TX_DONE},
        '{4'h4, OFF_RX_STARTED, E_RX_STARTED}, '{4'h5, OFF_TX_STARTED, E_TX_STARTED},
        '{4'h6, OFF_RX_TIMEOUT, E_RX_TIMEOUT}, '{4'h7, OFF_TX_STOPPED, E_TX_STOPPED},
        '{4'h8, OFF_ERROR, E_ERROR}, '{4'h9, OFF_ERROR, E_ERROR}};
    logic [11:0] trig[5] = '{OFF_RX_START_TRIG, OFF_RX_STOP_TRIG, OFF_TX_START_TRIG, OFF_TX_STOP_TRIG,
        OFF_RX_FLUSH_TRIG};
    logic [11:0] subs[5] = '{OFF_RX_START_SUB, OFF_RX_STOP_SUB, OFF_TX_START_SUB, OFF_TX_STOP_SUB,
        OFF_RX_FLUSH_SUB};

    always #4 i_ref_clk = ~i_ref_clk;

    serial_evt_regs u_serial_evt_regs (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_chan_pulse(i_chan_pulse),
        .i_cts_n(cts_n), .i_rx_byte(evt[0]), .i_rx_buf_full(evt[1]), .i_tx_byte(evt[2]),
        .i_tx_last(evt[3]), .i_rx_started(evt[4]), .i_tx_started(evt[5]), .i_rx_stopped(evt[6]),
        .i_tx_stopped(evt[7]), .i_frame_err(evt[8]), .i_break(evt[9]), .o_task(o_task), .o_irq(o_irq));
    far_serial_model u_far_serial_model (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_go(go), .i_sel(sel),
        .i_delay(dly), .i_cts_req(cts_req), .o_evt(evt), .o_cts_n(cts_n));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle write; returns at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    // One-cycle read; data taken in the following cycle
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Pulse one channel and count cycles where the expected task fires
    task automatic chan(input int ch, input logic [4:0] exp, output int hits);
        hits = 0;
        @(posedge i_ref_clk);
        i_chan_pulse <= 16'h0001 << ch;
        for (int k = 0; k < 6; k++) begin
            @(posedge i_ref_clk);
            if (k == 0) i_chan_pulse <= '0;
            #1 if (o_task === exp) hits++;
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Bound on the whole run
    initial begin
        #400000;
        num_errors++;
        print_verdict();
    end

    initial begin
        int h;
        repeat (16) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        // Event flags: set, hold through a write of one, clear by a write of zero
        foreach (rows[i]) begin
            rd(rows[i].off, rv);
            chk(rv, 32'h0);
            wr(OFF_IRQ_MASK, 32'h1 << rows[i].bit_i);
            @(posedge i_ref_clk);
            go <= 1'b1;
            sel <= rows[i].s;
            dly <= (i % 2) ? 4'h5 : 4'h0;
            @(posedge i_ref_clk);
            go <= 1'b0;
            h = 0;
            while (o_irq !== 1'b1 && h < 12) begin
                @(posedge i_ref_clk);
                #1 h++;
            end
            chk({31'h0, o_irq}, 32'h1);
            rd(rows[i].off, rv);
            chk(rv, 32'h1);
            wr(rows[i].off, 32'h1);
            rd(rows[i].off, rv);
            chk(rv, 32'h1);
            wr(rows[i].off, 32'h0);
            rd(rows[i].off, rv);
            chk(rv, 32'h0);
            chk({31'h0, o_irq}, 32'h0);
        end
        $display("test event_flags done");
        // Task triggers: zero does nothing, one pulses, reads give zero
        foreach (trig[t]) begin
            wr(trig[t], 32'h0);
            #1 chk({27'h0, o_task}, 32'h0);
            wr(trig[t], 32'h1);
            #1 chk({27'h0, o_task}, 32'h1 << t);
            rd(trig[t], rv);
            chk(rv, 32'h0);
        end
        $display("test triggers done");
        // Subscriptions: reset zero, read back, fire only while enabled
        foreach (subs[t]) begin
            rd(subs[t], rv);
            chk(rv, 32'h0);
            wr(subs[t], 32'h80000000 | (t + 3));
            rd(subs[t], rv);
            chk(rv, 32'h80000000 | (t + 3));
            chan(t + 4, 5'h1 << t, h);
            chk(h, 0);
            chan(t + 3, 5'h1 << t, h);
            chk(h, 1);
            wr(subs[t], t + 3);
            chan(t + 3, 5'h1 << t, h);
            chk(h, 0);
        end
        $display("test subscriptions done");
        // Clear-to-send edges, with the interrupt masked out
        wr(OFF_IRQ_MASK, 32'h0);
        cts_req <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        rd(OFF_CTS_ACT, rv);
        chk(rv, 32'h1);
        rd(OFF_CTS_INACT, rv);
        chk(rv, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        cts_req <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        rd(OFF_CTS_INACT, rv);
        chk(rv, 32'h1);
        $display("test clear_to_send done");
        // Mid-run reset: configuration, flags and outputs return to zero, no false pin edge
        wr(OFF_RX_START_SUB, 32'h80000002);
        wr(OFF_IRQ_MASK, 32'h1 << E_CTS_INACT);
        rd(OFF_RX_START_SUB, rv);
        chk(rv, 32'h80000002);
        chk({31'h0, o_irq}, 32'h1);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        #1 chk({26'h0, o_task, o_irq}, 32'h0);
        rd(OFF_RX_START_SUB, rv);
        chk(rv, 32'h0);
        rd(OFF_IRQ_MASK, rv);
        chk(rv, 32'h0);
        rd(OFF_CTS_INACT, rv);
        chk(rv, 32'h0);
        $display("test mid_reset done");
        // Unmapped read gives zero
        rd(12'h200, rv);
        chk(rv, 32'h0);
        $display("test unmapped done");
        print_verdict();
    end
endmodule
